// ===== prot_cfg.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Flags bit0 NAD, 1 ident, 2 auto-attr, 4 auto-ATS, 5 emulation, 6 padding; 3,7 zero.
// - Set-params without flag byte or with wrong length gets a syntax error.
// - Initiator omits NAD unless flag set; NAD then comes from exchange command.
// - Target forwards received NAD via get-data; host returns NAD via set-data.
// - Status byte MSB set when transport payload carries NAD values.
// - Ident flag inserts fixed identifier 0x01; clear sends none.
// - Auto-attr flag answers attribute request alone; else wait for host.
// - At 106 kbps, layer-4 card plus auto-ATS flag sends self-built RATS first.
// - Emulation flag makes device reply ATS to RATS; clear disables.
// - Padding flag drops 0x00 preamble and postamble from frames to host.
// - Defaults: no NAD, no ident, auto attr, auto ATS, emulation, padding kept.
// - Mode byte: 1 normal, 2 virtual, 3 wired, 4 dual card.
// - Virtual, wired and dual modes only for 106 kbps type A.
// - Timeout byte in 50 ms units; zero disables supervision.
// - Timeout required in virtual mode, optional and ignored elsewhere.
// - Interrupt byte 0 keeps pin high, 1 or absent lets device drive it.
// - Bad mode or interrupt byte, missing mode, missing virtual timeout give syntax error.
// - Normal mode routes nothing to secure module; initiator or target allowed.
// - Wired mode emits no field, ignores readers, reads secure module directly.
// - Virtual mode bridges reader and module; module answers everything.
// - Dual mode shows device and module as two separate targets.
// - Virtual mode watches module activity interrupt as transaction start.
// - Each activity interrupt is cleared so further bytes are seen.
// - Virtual mode notifies host when transaction probably ended.
module prot_cfg #(
  parameter int TICK_COUNT = prot_cfg_pkg::TICK_CYCLES // Cycles per 50 ms
) (
  input wire logic clk, // 125 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic secureInputActivityIrq, // Byte seen from secure module
  input wire logic transactionActiveLine, // Active-low transaction line
  input wire logic rfFieldPresent, // External field detected
  input wire logic cardLayer4, // SAK says layer-4 card
  input wire logic rate106A, // Link is 106 kbps type A
  input wire logic targetNadValid, // NAD received as target
  input wire logic [7:0] targetNadRx, // Received NAD value
  output logic secureIrqClear, // Clears the activity interrupt
  output logic hostInterruptPinOut, // Host interrupt pin level
  output logic hostInterruptPinOe, // Host interrupt pin enable
  output logic txNadEnable, // Insert NAD in initiator frames
  output logic txIdentEnable, // Insert identifier in frames
  output logic [7:0] txIdentValue, // Identifier value
  output logic autoAttrResponse, // Target answers attribute request alone
  output logic sendRatsFirst, // Send self-built RATS first
  output logic cardEmulation, // Answer RATS with ATS
  output logic keepPadding, // Frames carry preamble and postamble
  output logic rfFieldEnable, // Own field allowed
  output logic secureRouteBridge, // Analog bridge to secure module
  output logic secureRouteWired, // Device reads secure module
  output logic dualTarget // Two targets presented
);
  logic [7:0] flags_q; // node_addr_use_flag etc
  prot_cfg_pkg::secure_cfg_t cfg_q;
  prot_cfg_pkg::cmd_state_t state_q;
  logic [7:0] cmdCode_q;
  logic [2:0] argCount_q;
  logic [7:0] arg0_q, arg1_q, arg2_q;
  logic [7:0] respCode_q, respStatus_q;
  logic syntaxErr_q, endEvent_q, txnActive_q, irqLow_q;
  logic [7:0] nadRx_q;
  logic nadSeen_q;
  logic [31:0] tick_q;
  logic [7:0] toCount_q;
  logic lineLow_q;
  logic wbReq, wbWr, cmdStart, argPush, eventClear;
  logic flagsOk, cfgOk, modeOk, toOk, irqOk;
  logic endByLine, endByRf, endByTimeout;

  // Bus decode
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
  assign cmdStart = wbWr && (wb_adr_i == prot_cfg_pkg::REG_CMD) && (state_q == prot_cfg_pkg::CmdIdle);
  assign argPush = wbWr && (wb_adr_i == prot_cfg_pkg::REG_ARG) && (state_q == prot_cfg_pkg::CmdIdle);
  assign eventClear = wbWr && (wb_adr_i == prot_cfg_pkg::REG_EVENT) && wb_dat_i[prot_cfg_pkg::ST_END];

  // Ack one cycle after request
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  // Read mux
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wbReq && !wb_we_i) begin
      case (wb_adr_i)
        prot_cfg_pkg::REG_STATUS: wb_dat_o <= {16'h0000, respStatus_q, 4'h0, txnActive_q, endEvent_q,
                                               syntaxErr_q, (state_q != prot_cfg_pkg::CmdIdle)};
        prot_cfg_pkg::REG_CFG: wb_dat_o <= {7'h00, cfg_q.irqEnable, cfg_q.timeout, cfg_q.mode, flags_q};
        prot_cfg_pkg::REG_LINK: wb_dat_o <= {15'h0000, nadSeen_q, nadRx_q, respCode_q};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Argument collection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      argCount_q <= 3'h0;
      arg0_q <= 8'h00;
      arg1_q <= 8'h00;
      arg2_q <= 8'h00;
    end else if (state_q == prot_cfg_pkg::CmdAnswer) begin
      argCount_q <= 3'h0;
    end else if (argPush && argCount_q != 3'h4) begin
      case (argCount_q)
        3'h0: arg0_q <= wb_dat_i[7:0];
        3'h1: arg1_q <= wb_dat_i[7:0];
        default: arg2_q <= wb_dat_i[7:0];
      endcase
      argCount_q <= argCount_q + 3'h1; // Count 4 marks overlength
    end
  end

  // Validation
  assign flagsOk = (argCount_q == 3'h1) && !arg0_q[prot_cfg_pkg::FLAG_RSVD3]
                   && !arg0_q[prot_cfg_pkg::FLAG_RSVD7];
  assign modeOk = (argCount_q != 3'h0) && (arg0_q >= prot_cfg_pkg::MODE_NORMAL)
                  && (arg0_q <= prot_cfg_pkg::MODE_DUAL);
  assign toOk = (arg0_q != prot_cfg_pkg::MODE_VIRTUAL) || (argCount_q >= 3'h2);
  assign irqOk = (argCount_q < 3'h3) || (arg2_q == prot_cfg_pkg::IRQ_KEEP_HIGH)
                 || (arg2_q == prot_cfg_pkg::IRQ_DRIVEN);
  assign cfgOk = modeOk && toOk && irqOk && (argCount_q != 3'h4);

  // Command sequencer: apply then answer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= prot_cfg_pkg::CmdIdle;
      cmdCode_q <= 8'h00;
    end else begin
      case (state_q)
        prot_cfg_pkg::CmdIdle: if (cmdStart) begin
          cmdCode_q <= wb_dat_i[7:0];
          state_q <= prot_cfg_pkg::CmdApply;
        end
        prot_cfg_pkg::CmdApply: state_q <= prot_cfg_pkg::CmdAnswer;
        prot_cfg_pkg::CmdAnswer: state_q <= prot_cfg_pkg::CmdIdle;
        default: state_q <= prot_cfg_pkg::CmdIdle;
      endcase
    end
  end

  // Settings update in apply state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flags_q <= prot_cfg_pkg::FLAGS_RESET;
      cfg_q <= '{mode: prot_cfg_pkg::MODE_NORMAL, timeout: 8'h00, irqEnable: 1'b1};
    end else if (state_q == prot_cfg_pkg::CmdApply) begin
      if (cmdCode_q == prot_cfg_pkg::CMD_SET_PARAMS && flagsOk) begin
        flags_q <= arg0_q;
      end else if (cmdCode_q == prot_cfg_pkg::CMD_SECURE_CFG && cfgOk) begin
        cfg_q.mode <= arg0_q;
        cfg_q.timeout <= (argCount_q >= 3'h2) ? arg1_q : 8'h00;
        cfg_q.irqEnable <= (argCount_q < 3'h3) || (arg2_q == prot_cfg_pkg::IRQ_DRIVEN);
      end
    end
  end

  // Response after settings applied
  always_ff @(posedge clk) begin
    if (!rstn) begin
      respCode_q <= 8'h00;
      respStatus_q <= prot_cfg_pkg::STATUS_OK;
      syntaxErr_q <= 1'b0;
    end else if (state_q == prot_cfg_pkg::CmdApply) begin
      if (cmdCode_q == prot_cfg_pkg::CMD_SET_PARAMS) begin
        respCode_q <= prot_cfg_pkg::RSP_SET_PARAMS;
        syntaxErr_q <= !flagsOk;
      end else if (cmdCode_q == prot_cfg_pkg::CMD_SECURE_CFG) begin
        respCode_q <= prot_cfg_pkg::RSP_SECURE_CFG;
        syntaxErr_q <= !cfgOk;
      end else begin
        respCode_q <= 8'h00;
        syntaxErr_q <= 1'b1;
      end
      respStatus_q <= prot_cfg_pkg::STATUS_OK;
    end else if (state_q == prot_cfg_pkg::CmdAnswer) begin
      respStatus_q <= (syntaxErr_q ? prot_cfg_pkg::STATUS_SYNTAX_ERR : prot_cfg_pkg::STATUS_OK)
                      | (flags_q[prot_cfg_pkg::FLAG_NAD] ? prot_cfg_pkg::NAD_PRESENT_MASK : 8'h00);
    end
  end

  // Received NAD held for get-data
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nadRx_q <= 8'h00;
      nadSeen_q <= 1'b0;
    end else if (targetNadValid && flags_q[prot_cfg_pkg::FLAG_NAD]) begin
      nadRx_q <= targetNadRx;
      nadSeen_q <= 1'b1;
    end
  end

  // Flag-driven protocol controls
  assign txNadEnable = flags_q[prot_cfg_pkg::FLAG_NAD];
  assign txIdentEnable = flags_q[prot_cfg_pkg::FLAG_IDENT];
  assign txIdentValue = flags_q[prot_cfg_pkg::FLAG_IDENT] ? prot_cfg_pkg::IDENT_VALUE : 8'h00;
  assign autoAttrResponse = flags_q[prot_cfg_pkg::FLAG_AUTO_ATTR];
  assign sendRatsFirst = flags_q[prot_cfg_pkg::FLAG_AUTO_ATS] && cardLayer4 && rate106A;
  assign cardEmulation = flags_q[prot_cfg_pkg::FLAG_CARD_EMU];
  assign keepPadding = !flags_q[prot_cfg_pkg::FLAG_PAD_RM];

  // Mode-driven routing; secure modes need 106 kbps type A
  assign secureRouteBridge = (cfg_q.mode == prot_cfg_pkg::MODE_VIRTUAL) && rate106A;
  assign secureRouteWired = (cfg_q.mode == prot_cfg_pkg::MODE_WIRED) && rate106A;
  assign dualTarget = (cfg_q.mode == prot_cfg_pkg::MODE_DUAL) && rate106A;
  assign rfFieldEnable = (cfg_q.mode != prot_cfg_pkg::MODE_WIRED)
                         && (cfg_q.mode != prot_cfg_pkg::MODE_VIRTUAL);

  // Activity interrupt acknowledge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      secureIrqClear <= 1'b0;
    end else begin
      secureIrqClear <= secureInputActivityIrq && !secureIrqClear;
    end
  end

  // 50 ms tick and timeout countdown, restarted on activity while secureRouteBridge is set
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tick_q <= 32'h0000_0000;
      toCount_q <= 8'h00;
    end else if (secureInputActivityIrq && secureRouteBridge) begin
      tick_q <= 32'h0000_0000;
      toCount_q <= cfg_q.timeout;
    end else if (tick_q == 32'(TICK_COUNT - 1)) begin
      tick_q <= 32'h0000_0000;
      if (toCount_q != 8'h00) begin
        toCount_q <= toCount_q - 8'h01;
      end
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  // Transaction line level history
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lineLow_q <= 1'b0;
    end else begin
      lineLow_q <= !transactionActiveLine;
    end
  end

  assign endByLine = lineLow_q && transactionActiveLine && rfFieldPresent;
  assign endByRf = !rfFieldPresent;
  assign endByTimeout = (cfg_q.timeout != 8'h00) && (toCount_q == 8'h01)
                        && (tick_q == 32'(TICK_COUNT - 1));

  // Transaction tracking and sticky end event; set wins over clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      txnActive_q <= 1'b0;
      endEvent_q <= 1'b0;
    end else if (!secureRouteBridge) begin
      txnActive_q <= 1'b0;
      endEvent_q <= endEvent_q && !eventClear;
    end else if (secureInputActivityIrq) begin
      txnActive_q <= 1'b1;
      endEvent_q <= endEvent_q && !eventClear;
    end else if (txnActive_q && (endByLine || endByRf || endByTimeout)) begin
      txnActive_q <= 1'b0;
      endEvent_q <= 1'b1;
    end else begin
      endEvent_q <= endEvent_q && !eventClear;
    end
  end

  // Host interrupt pin, released on next command
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irqLow_q <= 1'b0;
    end else if (txnActive_q && secureRouteBridge && (endByLine || endByRf || endByTimeout)) begin
      irqLow_q <= cfg_q.irqEnable;
    end else if (cmdStart) begin
      irqLow_q <= 1'b0;
    end
  end

  assign hostInterruptPinOut = !irqLow_q;
  assign hostInterruptPinOe = cfg_q.irqEnable;
endmodule // prot_cfg
`default_nettype wire

// ===== prot_cfg_pkg.sv
package prot_cfg_pkg;
  // Command codes and response codes
  localparam logic [7:0] CMD_SET_PARAMS = 8'h12;
  localparam logic [7:0] CMD_SECURE_CFG = 8'h14;
  localparam logic [7:0] RSP_SET_PARAMS = 8'h13;
  localparam logic [7:0] RSP_SECURE_CFG = 8'h15;
  localparam logic [7:0] STATUS_SYNTAX_ERR = 8'h27;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] NAD_PRESENT_MASK = 8'h80;
  // Flag byte field positions
  localparam int FLAG_NAD = 0;
  localparam int FLAG_IDENT = 1;
  localparam int FLAG_AUTO_ATTR = 2;
  localparam int FLAG_RSVD3 = 3;
  localparam int FLAG_AUTO_ATS = 4;
  localparam int FLAG_CARD_EMU = 5;
  localparam int FLAG_PAD_RM = 6;
  localparam int FLAG_RSVD7 = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h34;
  localparam logic [7:0] IDENT_VALUE = 8'h01;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  // Secure module modes
  localparam logic [7:0] MODE_NORMAL = 8'h01;
  localparam logic [7:0] MODE_VIRTUAL = 8'h02;
  localparam logic [7:0] MODE_WIRED = 8'h03;
  localparam logic [7:0] MODE_DUAL = 8'h04;
  localparam logic [7:0] IRQ_KEEP_HIGH = 8'h00;
  localparam logic [7:0] IRQ_DRIVEN = 8'h01;
  // Timeout tick: 50 ms at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int TIMEOUT_UNIT_MS = 50;
  localparam int TICK_CYCLES = TIMEOUT_UNIT_MS * 1000 * CLK_MHZ;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ARG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam logic [7:0] REG_LINK = 8'h10;
  localparam logic [7:0] REG_EVENT = 8'h14;
  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_SYNTAX = 1;
  localparam int ST_END = 2;
  localparam int ST_ACTIVE = 3;

  typedef enum {CmdIdle, CmdApply, CmdAnswer} cmd_state_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] timeout;
    logic irqEnable;
  } secure_cfg_t;
endpackage

// ===== prot_cfg_props.sv
`timescale 1ns/100ps
`default_nettype none
module prot_cfg_props (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Acknowledge
  input wire logic secureInputActivityIrq, // Module byte seen
  input wire logic secureIrqClear, // Activity clear
  input wire logic hostInterruptPinOut, // Host pin level
  input wire logic hostInterruptPinOe, // Host pin enable
  input wire logic txIdentEnable, // Identifier insert
  input wire logic [7:0] txIdentValue, // Identifier value
  input wire logic sendRatsFirst, // Self-built RATS
  input wire logic cardLayer4, // Layer-4 card
  input wire logic rate106A, // 106 kbps type A
  input wire logic rfFieldEnable, // Own field allowed
  input wire logic secureRouteBridge, // Bridge route
  input wire logic secureRouteWired, // Wired route
  input wire logic dualTarget // Two targets
);
  // One clock domain, one reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Bus answer timing
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  // Field mapping to outputs
  a_ident_fixed: assert property (txIdentValue == (txIdentEnable ? 8'h01 : 8'h00)) else $error("ident value");
  a_rats_cause: assert property (sendRatsFirst |-> cardLayer4 && rate106A) else $error("rats cause");
  a_routes_rate: assert property (secureRouteBridge || secureRouteWired || dualTarget |-> rate106A) else $error("rate");
  a_routes_onehot: assert property ($onehot0({secureRouteBridge, secureRouteWired, dualTarget})) else $error("routes");
  a_wired_nofield: assert property (secureRouteWired |-> !rfFieldEnable) else $error("wired field");
  a_bridge_nofield: assert property (secureRouteBridge |-> !rfFieldEnable) else $error("bridge field");
  a_pin_idle_high: assert property (!hostInterruptPinOe |-> hostInterruptPinOut) else $error("pin not high");
  a_irq_cleared: assert property (secureInputActivityIrq && !secureIrqClear && secureRouteBridge |-> ##1 secureIrqClear)
    else $error("activity not cleared");
endmodule // prot_cfg_props
`default_nettype wire

// ===== secure_module_model.sv
`timescale 1ns/100ps
`default_nettype none
module secure_module_model (
  input wire logic clk, // Clock
  input wire logic go, // Start one exchange
  input wire logic useLine, // Module drives the transaction line
  input wire logic irqClear, // Clear from device
  output logic activityIrq, // Byte sent to device
  output logic txnLine // Active-low transaction line
);
  logic [3:0] cnt_q;
  initial begin
    activityIrq = 1'b0;
    txnLine = 1'b1;
    cnt_q = 4'h0;
  end
  // Interrupt stays raised until the device clears it
  always @(posedge clk) begin
    if (go) begin
      activityIrq <= 1'b1;
    end else if (irqClear) begin
      activityIrq <= 1'b0;
    end
  end
  // Line held low for a short transaction, then released
  always @(posedge clk) begin
    if (go && useLine) begin
      txnLine <= 1'b0;
      cnt_q <= 4'hA;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      txnLine <= (cnt_q == 4'h1);
    end
  end
endmodule // secure_module_model
`default_nettype wire

// ===== prot_cfg_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t %s", $time, m); end end
module prot_cfg_test;
  logic clk, rstn, cyc, stb, we, go, useLine, irqClr, actIrq, txnLine, rf, l4, r106, nadV;
  logic [7:0] adr, nad;
  logic [31:0] dat, rd, wbQ;
  logic ack, pinOut, pinOe, nadEn, idEn, attr, rats, emu, keep, field, brg, wired, dual;
  logic [7:0] idVal;
  int n_fail = 0;
  int compares = 0;
  prot_cfg #(.TICK_COUNT(10)) uut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wbQ), .wb_ack_o(ack),
    .secureInputActivityIrq(actIrq), .transactionActiveLine(txnLine), .rfFieldPresent(rf), .cardLayer4(l4),
    .rate106A(r106), .targetNadValid(nadV), .targetNadRx(nad), .secureIrqClear(irqClr),
    .hostInterruptPinOut(pinOut), .hostInterruptPinOe(pinOe), .txNadEnable(nadEn), .txIdentEnable(idEn),
    .txIdentValue(idVal), .autoAttrResponse(attr), .sendRatsFirst(rats), .cardEmulation(emu),
    .keepPadding(keep), .rfFieldEnable(field), .secureRouteBridge(brg), .secureRouteWired(wired),
    .dualTarget(dual));
  secure_module_model sam (.clk(clk), .go(go), .useLine(useLine), .irqClear(irqClr), .activityIrq(actIrq),
    .txnLine(txnLine));
  // Clock, 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Classic single bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 40);
    rd = wbQ; // Taken at the edge that samples ack high
    if (n >= 40) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Arguments, command code, then poll until idle
  task automatic cmd(input logic [7:0] c, input int n, input logic [23:0] a);
    int k;
    k = 0;
    for (int i = 0; i < n; i++) wb(1'b1, prot_cfg_pkg::REG_ARG, {24'h0, a[8*i +: 8]});
    wb(1'b1, prot_cfg_pkg::REG_CMD, {24'h0, c});
    do begin wb(1'b0, prot_cfg_pkg::REG_STATUS, 32'h0); k++; end while (rd[0] !== 1'b0 && k < 10);
  endtask
  task automatic t_defaults;
    wb(1'b0, prot_cfg_pkg::REG_CFG, 32'h0);
    `CHK(rd, 32'h0100_0134, "cfg reset")
    `CHK({nadEn, idEn, attr, emu, keep}, 5'b00111, "default flags")
    `CHK({rats, pinOe, pinOut}, 3'b111, "default rats/pin")
    wb(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
  endtask
  task automatic t_flags;
    cmd(prot_cfg_pkg::CMD_SET_PARAMS, 1, 24'h43);
    `CHK(rd[15:8], 8'h80, "nad mark")
    `CHK({nadEn, idEn, attr, emu, keep}, 5'b11000, "flag outputs")
    `CHK({idVal, rats}, 9'h002, "ident 01, no rats")
    wb(1'b0, prot_cfg_pkg::REG_LINK, 32'h0);
    `CHK(rd[16:0], 17'h15A13, "link code and nad")
    cmd(prot_cfg_pkg::CMD_SET_PARAMS, 0, 24'h0);
    `CHK(rd[1], 1'b1, "missing flags")
    cmd(prot_cfg_pkg::CMD_SET_PARAMS, 2, 24'h0034);
    `CHK(rd[1], 1'b1, "overlength")
    wb(1'b0, prot_cfg_pkg::REG_CFG, 32'h0);
    `CHK(rd[7:0], 8'h43, "flags kept")
    cmd(prot_cfg_pkg::CMD_SET_PARAMS, 1, 24'h34);
    `CHK({idVal, nadEn, keep}, 10'h001, "ident cleared")
  endtask
  task automatic t_modes;
    logic [3:0] e;
    for (int m = 1; m <= 4; m++) begin
      cmd(prot_cfg_pkg::CMD_SECURE_CFG, (m == 2) ? 2 : 1, 24'(m));
      e = (m == 1) ? 4'b1000 : (m == 2) ? 4'b0100 : (m == 3) ? 4'b0010 : 4'b1001;
      `CHK({field, brg, wired, dual}, e, "mode routes")
    end
    r106 <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(dual, 1'b0, "dual needs 106A")
    r106 <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      cmd(prot_cfg_pkg::CMD_SECURE_CFG, (j == 2) ? 0 : 1, (j == 0) ? 24'h02 : 24'h05);
      `CHK(rd[1], 1'b1, "bad mode args")
    end
    cmd(prot_cfg_pkg::CMD_SECURE_CFG, 3, 24'h000001);
    `CHK({pinOe, pinOut}, 2'b01, "irq byte zero")
  endtask
  task automatic t_virtual;
    rf <= 1'b1;
    cmd(prot_cfg_pkg::CMD_SECURE_CFG, 3, 24'h010002);
    go <= 1'b1; useLine <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (40) @(posedge clk);
    wb(1'b0, prot_cfg_pkg::REG_STATUS, 32'h0);
    `CHK({rd[2], pinOut}, 2'b10, "line end notifies")
    wb(1'b1, prot_cfg_pkg::REG_EVENT, 32'h4);
    wb(1'b0, prot_cfg_pkg::REG_STATUS, 32'h0);
    `CHK(rd[2], 1'b0, "end cleared")
    cmd(prot_cfg_pkg::CMD_SECURE_CFG, 3, 24'h010202);
    `CHK(pinOut, 1'b1, "pin released by command")
    go <= 1'b1; useLine <= 1'b0;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) @(posedge clk);
    wb(1'b0, prot_cfg_pkg::REG_STATUS, 32'h0);
    `CHK(rd[2], 1'b0, "timeout early")
    repeat (30) @(posedge clk);
    wb(1'b0, prot_cfg_pkg::REG_STATUS, 32'h0);
    `CHK(rd[2], 1'b1, "timeout end")
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; go = 1'b0; useLine = 1'b0;
    rf = 1'b0; l4 = 1'b1; r106 = 1'b1; nadV = 1'b1; nad = 8'h5A;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_flags();
    t_modes();
    t_virtual();
    end_sim();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule // prot_cfg_test
bind prot_cfg prot_cfg_props u_props (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .secureInputActivityIrq(secureInputActivityIrq), .secureIrqClear(secureIrqClear),
  .hostInterruptPinOut(hostInterruptPinOut), .hostInterruptPinOe(hostInterruptPinOe),
  .txIdentEnable(txIdentEnable), .txIdentValue(txIdentValue), .sendRatsFirst(sendRatsFirst),
  .cardLayer4(cardLayer4), .rate106A(rate106A), .rfFieldEnable(rfFieldEnable),
  .secureRouteBridge(secureRouteBridge), .secureRouteWired(secureRouteWired), .dualTarget(dualTarget));
`default_nettype wire
